//--- verilog/aitc_cfg.svh
// constants of the trigger and conversion-clock control block
`ifndef AITC_CFG_SVH
`define AITC_CFG_SVH
`define AITC_SYS_MHZ 250
`define AITC_TB_MHZ 100
`define AITC_MAX_KSPS 250
`define AITC_MIN_DIV ((`AITC_TB_MHZ * 1000) / `AITC_MAX_KSPS)
`define AITC_DIV_W 32
`define AITC_DLY_W 24
`define AITC_CODE_W 16
`define AITC_NCH 32
`define AITC_CH_W 5
`define AITC_ACC_W 8
`define AITC_MID_CODE 16'h8000
`define AITC_BUF_DEPTH 2
`endif

//--- verilog/aitc_pkg.sv
// types shared by the trigger and conversion-clock control block
`include "aitc_cfg.svh"
package aitc_pkg;
    typedef enum logic [1:0] {
        AITC_MODE_START = 2'b00,
        AITC_MODE_DLY_START = 2'b01,
        AITC_MODE_STOP = 2'b10,
        AITC_MODE_DLY_STOP = 2'b11
    } aitc_mode_e;
    typedef enum logic [2:0] {
        AITC_GAIN_HALF = 3'b000,
        AITC_GAIN_1 = 3'b001,
        AITC_GAIN_2 = 3'b010,
        AITC_GAIN_4 = 3'b011,
        AITC_GAIN_8 = 3'b100
    } aitc_gain_e;
    typedef enum logic [2:0] {
        AITC_ST_IDLE = 3'b000,
        AITC_ST_ARMED = 3'b001,
        AITC_ST_DELAY = 3'b010,
        AITC_ST_RUN = 3'b011,
        AITC_ST_POST = 3'b100,
        AITC_ST_DONE = 3'b101
    } aitc_state_e;
    // per-channel gain and range
    typedef struct packed {
        aitc_gain_e gain;
        logic bipolar;
    } aitc_chcfg_s;
    // one converted sample with its channel setting
    typedef struct packed {
        logic [`AITC_CH_W-1:0] chan;
        aitc_chcfg_s cfg;
        logic [`AITC_CODE_W-1:0] code;
        logic [`AITC_CODE_W-1:0] value;
    } aitc_sample_s;
    // two-flop synchroniser plus an edge history flop
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
    } aitc_sync_s;
endpackage

//--- verilog/aitc_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "aitc_cfg.svh"
module aitc_skid_buf #(
    parameter int W = 8
) (
    input wire logic sys_clk_in, // system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic in_valid_in, // word offered
    input wire logic [W-1:0] in_data_in, // offered word
    output logic in_ready_out, // room for a word
    output logic out_valid_out, // head word valid
    output logic [W-1:0] out_data_out, // head word
    input wire logic out_ready_in // receiver takes head
);
    typedef struct packed {
        logic [`AITC_BUF_DEPTH-1:0][W-1:0] mem;
        logic [1:0] cnt;
        logic rdy;
    } aitc_buf_s;
    aitc_buf_s st_q, st_d;
    logic push;
    logic pop;
    // ready comes from a flop, so a full buffer refuses the next word
    always_comb begin
        st_d = st_q;
        push = in_valid_in && st_q.rdy;
        pop = out_ready_in && (st_q.cnt != 2'h0);
        if (pop) begin
            st_d.mem[0] = st_q.mem[1];
        end
        if (push) begin
            if (st_q.cnt == 2'h0 || (st_q.cnt == 2'h1 && pop)) begin
                st_d.mem[0] = in_data_in;
            end else begin
                st_d.mem[1] = in_data_in;
            end
        end
        st_d.cnt = st_q.cnt + {1'b0, push} - {1'b0, pop};
        st_d.rdy = (st_d.cnt != 2'(`AITC_BUF_DEPTH));
    end
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= '{mem: '0, cnt: 2'h0, rdy: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end
    assign in_ready_out = st_q.rdy;
    assign out_valid_out = (st_q.cnt != 2'h0);
    assign out_data_out = st_q.mem[0];
endmodule

//--- verilog/aitc_pacer.sv
// conversion pacing: divided timebase or synchronised external clock
`timescale 1ns/1ps
`include "aitc_cfg.svh"
module aitc_pacer
    import aitc_pkg::*;
#(
    parameter int DIV_W = `AITC_DIV_W
) (
    input wire logic sys_clk_in, // system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic run_in, // pacing allowed
    input wire logic ext_sel_in, // 1 = external pacing clock
    input wire logic [DIV_W-1:0] divisor_in, // timebase divisor
    input wire logic ext_clk_in, // external pacing clock pin
    output logic tick_out // one-cycle conversion pulse
);
    typedef struct packed {
        logic [`AITC_ACC_W-1:0] acc;
        logic [DIV_W-1:0] div_cnt;
        aitc_sync_s ext;
        logic tick;
    } aitc_pacer_s;
    aitc_pacer_s st_q, st_d;
    logic tb_tick;
    logic [DIV_W-1:0] div_eff;
    // fractional accumulator makes a 100 MHz tick from the system clock
    always_comb begin
        st_d = st_q;
        tb_tick = 1'b0;
        div_eff = divisor_in;
        st_d.ext.s1 = ext_clk_in;
        st_d.ext.s2 = st_q.ext.s1;
        st_d.ext.prev = st_q.ext.s2;
        // compare before adding, so the narrow sum can never wrap and lose ticks
        if (st_q.acc >= `AITC_ACC_W'(`AITC_SYS_MHZ - `AITC_TB_MHZ)) begin
            st_d.acc = st_q.acc - `AITC_ACC_W'(`AITC_SYS_MHZ - `AITC_TB_MHZ);
            tb_tick = 1'b1;
        end else begin
            st_d.acc = st_q.acc + `AITC_ACC_W'(`AITC_TB_MHZ);
        end
        // a small divisor is raised so the rate never passes the ceiling [R8]
        if (divisor_in < DIV_W'(`AITC_MIN_DIV)) begin
            div_eff = DIV_W'(`AITC_MIN_DIV);
        end
        st_d.tick = 1'b0;
        if (!run_in) begin
            st_d.div_cnt = '0;
        end else if (ext_sel_in) begin
            st_d.tick = st_q.ext.s2 && !st_q.ext.prev; // [R9]
        end else if (tb_tick) begin
            if (st_q.div_cnt >= div_eff - DIV_W'(1)) begin // [R7]
                st_d.div_cnt = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.div_cnt = st_q.div_cnt + DIV_W'(1);
            end
        end
    end
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign tick_out = st_q.tick;
endmodule

//--- verilog/aitc_ctrl.sv
// trigger and conversion-clock control for the analog input path
//
// Notes on behaviour
// R1: in start-trigger mode conversions before the trigger are blocked, then run until stop.
// R2: in delay-to-start mode a preset number of conversion clocks pass after the trigger first.
// R3: one 24-bit counter holds the delay or post-trigger count.
// R4: in delay-to-stop mode acquisition runs from start and ends a preset count after trigger.
// R5: in stop-trigger mode acquisition runs from start and ends at the trigger.
// R6: software picks internal or external pacing and the trigger source.
// R7: internal pacing divides a 100 MHz timebase by a 32-bit divisor.
// R8: internal pacing never exceeds 250 KS/s.
// R9: with external pacing each rising edge of that clock starts one conversion.
// R10: the external pacing clock is kept at or below 250 kHz by its source.
// R11: triggers come from a TTL input or an analog comparator, either edge selectable.
// R12: a digital trigger is the chosen edge on the synchronised TTL input.
// R13: an analog trigger is the chosen crossing of the threshold by the comparator.
// R14: the threshold is a 16-bit value sent to the threshold converter.
// R15: samples are straight binary unipolar and offset binary bipolar.
// R16: each channel has its own gain and range; gain one half only for bipolar.
// R17: a software stop blocks further conversions and clears the delay count.
`timescale 1ns/1ps
`include "aitc_cfg.svh"
module aitc_ctrl
    import aitc_pkg::*;
(
    input wire logic sys_clk_in, // 250 MHz system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic start_in, // software start pulse
    input wire logic stop_in, // software stop pulse
    input wire aitc_mode_e mode_in, // trigger mode
    input wire logic [`AITC_DLY_W-1:0] delay_in, // delay or post count
    input wire logic ext_clk_sel_in, // 1 = external pacing
    input wire logic [`AITC_DIV_W-1:0] divisor_in, // timebase divisor
    input wire logic trig_analog_sel_in, // 1 = analog trigger
    input wire logic trig_fall_in, // 1 = falling edge
    input wire logic [`AITC_CODE_W-1:0] threshold_in, // trigger level
    input wire logic conversion_pacing_clock_in, // external pacing pin
    input wire logic ext_trig_in, // TTL trigger pin
    input wire logic analog_trigger_inputs_in, // comparator: above level
    input wire logic cfg_we_in, // channel setting write
    input wire logic [`AITC_CH_W-1:0] cfg_chan_in, // channel written
    input wire aitc_chcfg_s cfg_in, // gain and range
    input wire logic adc_valid_in, // converter result valid
    input wire logic [`AITC_CH_W-1:0] adc_chan_in, // result channel
    input wire logic [`AITC_CODE_W-1:0] adc_code_in, // result code
    input wire logic smp_ready_in, // sample buffer accepts
    output logic adc_ready_out, // room for a result
    output logic conv_start_out, // start one conversion
    output logic [`AITC_CODE_W-1:0] threshold_dac_out, // threshold code
    output logic acquiring_out, // acquisition active
    output logic armed_out, // waiting for trigger or delay
    output logic done_out, // acquisition ended by trigger
    output logic overrun_out, // result lost, sticky
    output logic cfg_err_out, // last setting refused
    output logic smp_valid_out, // sample valid
    output aitc_sample_s smp_out // sample with setting
);
    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        aitc_state_e fsm;
        logic [`AITC_DLY_W-1:0] cnt;
        aitc_sync_s dtrg;
        aitc_sync_s atrg;
        logic conv;
        logic acq;
        logic armed;
        logic done;
        logic ovr;
        logic cfg_err;
        logic [`AITC_CODE_W-1:0] dac;
        logic [`AITC_NCH-1:0][$bits(aitc_chcfg_s)-1:0] chcfg;
    } aitc_ctrl_s;
    aitc_ctrl_s st_q, st_d;
    logic tick;
    logic pace_run;
    logic ev;
    logic ev_dig;
    logic ev_ana;
    logic buf_ready;
    logic buf_valid;
    aitc_sample_s buf_data;
    aitc_sample_s smp_in;
    aitc_chcfg_s res_cfg;

    // ************************************************************
    // helpers
    // ************************************************************
    // chosen edge of a synchronised level, read only after the second flop
    function automatic logic edge_hit(input aitc_sync_s s, input logic fall);
        edge_hit = fall ? (s.prev && !s.s2) : (!s.prev && s.s2);
    endfunction

    // ************************************************************
    // pacing
    // ************************************************************
    // pacing runs in every state but idle and done, including the armed wait where no tick is used
    assign pace_run = (st_q.fsm != AITC_ST_IDLE) && (st_q.fsm != AITC_ST_DONE);
    aitc_pacer #(
        .DIV_W(`AITC_DIV_W)
    ) u_pacer (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .run_in(pace_run),
        .ext_sel_in(ext_clk_sel_in), // [R6]
        .divisor_in(divisor_in),
        .ext_clk_in(conversion_pacing_clock_in),
        .tick_out(tick)
    );

    // ************************************************************
    // trigger detection
    // ************************************************************
    assign ev_dig = edge_hit(st_q.dtrg, trig_fall_in); // [R12] [R11]
    assign ev_ana = edge_hit(st_q.atrg, trig_fall_in); // [R13] [R11]
    assign ev = trig_analog_sel_in ? ev_ana : ev_dig; // [R6]

    // ************************************************************
    // sample path
    // ************************************************************
    // tag each result with its channel's setting and, on a bipolar range, a signed view
    always_comb begin
        res_cfg = aitc_chcfg_s'(st_q.chcfg[adc_chan_in]);
        smp_in.chan = adc_chan_in;
        smp_in.cfg = res_cfg;
        smp_in.code = adc_code_in;
        // offset binary becomes two's complement, straight binary passes [R15]
        smp_in.value = res_cfg.bipolar ? (adc_code_in ^ `AITC_MID_CODE) : adc_code_in;
    end

    // two entries so a receiver stall does not drop a word in flight
    aitc_skid_buf #(
        .W($bits(aitc_sample_s))
    ) u_buf (
        .sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in),
        .in_valid_in(adc_valid_in),
        .in_data_in(smp_in),
        .in_ready_out(buf_ready),
        .out_valid_out(buf_valid),
        .out_data_out(buf_data),
        .out_ready_in(smp_ready_in)
    );

    // ************************************************************
    // control
    // ************************************************************
    always_comb begin
        st_d = st_q;
        st_d.dtrg.s1 = ext_trig_in;
        st_d.dtrg.s2 = st_q.dtrg.s1;
        st_d.dtrg.prev = st_q.dtrg.s2;
        st_d.atrg.s1 = analog_trigger_inputs_in;
        st_d.atrg.s2 = st_q.atrg.s1;
        st_d.atrg.prev = st_q.atrg.s2;
        st_d.dac = threshold_in; // [R14]
        st_d.conv = 1'b0;
        // channel settings; one half gain on a unipolar range is refused
        if (cfg_we_in) begin
            if ((cfg_in.gain == AITC_GAIN_HALF && !cfg_in.bipolar) ||
                (cfg_in.gain > AITC_GAIN_8)) begin // [R16]
                st_d.cfg_err = 1'b1;
            end else begin
                st_d.cfg_err = 1'b0;
                st_d.chcfg[cfg_chan_in] = cfg_in; // [R16]
            end
        end
        case (st_q.fsm)
            AITC_ST_IDLE: begin
                if (start_in) begin
                    st_d.cnt = delay_in; // [R3]
                    st_d.done = 1'b0;
                    st_d.ovr = 1'b0;
                    if (mode_in == AITC_MODE_STOP || mode_in == AITC_MODE_DLY_STOP) begin
                        st_d.fsm = AITC_ST_RUN; // [R4] [R5]
                    end else begin
                        st_d.fsm = AITC_ST_ARMED;
                    end
                end
            end
            AITC_ST_ARMED: begin
                // pacing ticks here are dropped until the trigger [R1]
                if (ev) begin
                    if (mode_in == AITC_MODE_DLY_START) begin
                        st_d.fsm = AITC_ST_DELAY; // [R2]
                    end else begin
                        st_d.fsm = AITC_ST_RUN; // [R1]
                    end
                end
            end
            AITC_ST_DELAY: begin
                if (tick) begin
                    if (st_q.cnt <= `AITC_DLY_W'(1)) begin
                        st_d.fsm = AITC_ST_RUN; // [R2]
                    end else begin
                        st_d.cnt = st_q.cnt - `AITC_DLY_W'(1); // [R3]
                    end
                end
            end
            AITC_ST_RUN: begin
                if (ev && mode_in == AITC_MODE_STOP) begin
                    st_d.fsm = AITC_ST_DONE; // [R5]
                    st_d.done = 1'b1;
                end else begin
                    st_d.conv = tick;
                    if (ev && mode_in == AITC_MODE_DLY_STOP) begin
                        st_d.fsm = AITC_ST_POST; // [R4]
                    end
                end
            end
            AITC_ST_POST: begin
                st_d.conv = tick;
                if (tick) begin
                    if (st_q.cnt <= `AITC_DLY_W'(1)) begin
                        st_d.fsm = AITC_ST_DONE; // [R4]
                        st_d.done = 1'b1;
                    end else begin
                        st_d.cnt = st_q.cnt - `AITC_DLY_W'(1); // [R3]
                    end
                end
            end
            AITC_ST_DONE: begin
                // samples stay in the buffer; a start returns to idle, and a second start rearms [R4]
                if (start_in) begin
                    st_d.fsm = AITC_ST_IDLE;
                end
            end
            default: begin
                st_d.fsm = AITC_ST_IDLE;
            end
        endcase
        // stop wins over the state, count and conversion pulse, but a trigger in the same cycle still sets done
        if (stop_in) begin
            st_d.fsm = AITC_ST_IDLE; // [R17]
            st_d.cnt = '0; // [R17]
            st_d.conv = 1'b0; // [R17]
        end
        // a result offered while full is lost; set wins, only start clears
        if (adc_valid_in && !buf_ready) begin
            st_d.ovr = 1'b1;
        end
        st_d.acq = (st_d.fsm == AITC_ST_RUN) || (st_d.fsm == AITC_ST_POST);
        st_d.armed = (st_d.fsm == AITC_ST_ARMED) || (st_d.fsm == AITC_ST_DELAY);
    end

    // single register stage for all control state
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // every output is a flop of this module or of the buffer, except smp_valid_out, which is decoded from the buffer count
    assign adc_ready_out = buf_ready;
    assign conv_start_out = st_q.conv;
    assign threshold_dac_out = st_q.dac;
    assign acquiring_out = st_q.acq;
    assign armed_out = st_q.armed;
    assign done_out = st_q.done;
    assign overrun_out = st_q.ovr;
    assign cfg_err_out = st_q.cfg_err;
    assign smp_valid_out = buf_valid;
    assign smp_out = buf_data;
endmodule

//--- sim/aitc_adc_model.sv
// behavioural converter and external pacing clock source
`timescale 1ns/1ps
`include "aitc_cfg.svh"
module aitc_adc_model #(
    parameter int LAT = 20
) (
    input wire logic sys_clk_in, // clock
    input wire logic en_in, // run the pacing clock
    input wire logic conv_start_in, // start one conversion
    output logic pclk_out, // pacing clock pin
    output logic adc_valid_out, // result valid
    output logic [`AITC_CH_W-1:0] adc_chan_out, // result channel
    output logic [`AITC_CODE_W-1:0] adc_code_out // result code
);
    // ******
    // pacing and conversion
    // ******
    int cnt = 0;
    logic [`AITC_CODE_W-1:0] nxt = 16'h0123;
    initial begin
        {pclk_out, adc_valid_out, adc_chan_out, adc_code_out} = '0;
    end
    // 4 us period keeps the source at 250 kHz; the pin stands low while disabled
    always #2000 pclk_out = en_in & ~pclk_out;
    // a real converter never waits: a result the block cannot take is simply lost
    always @(posedge sys_clk_in) begin
        adc_valid_out <= (cnt == 1);
        adc_code_out <= (cnt == 1) ? nxt : ~adc_code_out;
        if (cnt == 1) begin
            nxt <= nxt + 16'h1111;
            adc_chan_out <= {4'h0, ~adc_chan_out[0]};
        end
        cnt <= conv_start_in ? LAT : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule

//--- sim/aitc_ctrl_assertions.sv
// concurrent checks on the ports of the acquisition control block
`timescale 1ns/1ps
`include "aitc_cfg.svh"
module aitc_ctrl_assertions
    import aitc_pkg::*;
(
    input wire logic sys_clk_in, // clock
    input wire logic nrst_in, // reset
    input wire logic stop_in, // stop
    input wire aitc_mode_e mode_in, // mode
    input wire logic [`AITC_CODE_W-1:0] threshold_in, // level
    input wire logic cfg_we_in, // write
    input wire aitc_chcfg_s cfg_in, // setting
    input wire logic adc_valid_in, // result
    input wire logic smp_ready_in, // taker ready
    input wire logic adc_ready_out, // room
    input wire logic conv_start_out, // conversion
    input wire logic [`AITC_CODE_W-1:0] threshold_dac_out, // dac code
    input wire logic acquiring_out, // running
    input wire logic armed_out, // waiting
    input wire logic overrun_out, // lost word
    input wire logic cfg_err_out, // refused
    input wire logic smp_valid_out, // sample valid
    input wire aitc_sample_s smp_out // sample
);
    // ******
    // helpers
    // ******
    logic bad_cfg;
    logic [11:0] gap_q;
    logic [11:0] gap_d;
    assign bad_cfg = (cfg_in.gain > AITC_GAIN_8) || (cfg_in.gain == AITC_GAIN_HALF && !cfg_in.bipolar);
    // cycles since the last pulse, saturating so a long idle spell never wraps
    always_comb begin
        gap_d = conv_start_out ? 12'h001 : (gap_q == 12'hfff ? gap_q : gap_q + 12'h001);
    end
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gap_q <= 12'hfff;
        end else begin
            gap_q <= gap_d;
        end
    end
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    // ******
    // properties
    // ******
    a_rate_limit: assert property (conv_start_out |-> gap_q >= 12'h3e3)
        else $error("conversion pulses closer than the rate limit");
    a_conv_acq: assert property (conv_start_out |-> acquiring_out || $past(acquiring_out))
        else $error("conversion outside acquisition");
    a_start_gate: assert property ($rose(acquiring_out) && mode_in inside {AITC_MODE_START,
        AITC_MODE_DLY_START} |-> $past(armed_out))
        else $error("acquisition began without waiting for the trigger");
    a_stop_halts: assert property (stop_in |=> !acquiring_out && !armed_out && !conv_start_out)
        else $error("activity after stop");
    a_dac_copy: assert property ($past(nrst_in) |-> threshold_dac_out == $past(threshold_in))
        else $error("threshold code not passed on");
    a_cfg_answer: assert property (cfg_we_in |=> cfg_err_out == $past(bad_cfg))
        else $error("channel setting answer wrong");
    a_overrun_set: assert property (adc_valid_in && !adc_ready_out |=> overrun_out)
        else $error("lost result not flagged");
    a_smp_hold: assert property (smp_valid_out && !smp_ready_in |=> smp_valid_out && $stable(smp_out))
        else $error("stalled sample changed");
    a_value_map: assert property (smp_valid_out |-> smp_out.value == (smp_out.code ^
        (smp_out.cfg.bipolar ? `AITC_MID_CODE : 16'h0000)))
        else $error("sample value coding wrong");
endmodule
bind aitc_ctrl aitc_ctrl_assertions u_aitc_ctrl_assertions (.sys_clk_in, .nrst_in, .stop_in,
    .mode_in, .threshold_in, .cfg_we_in, .cfg_in, .adc_valid_in, .smp_ready_in, .adc_ready_out,
    .conv_start_out, .threshold_dac_out, .acquiring_out, .armed_out, .overrun_out, .cfg_err_out,
    .smp_valid_out, .smp_out);

//--- sim/tb_aitc_ctrl.sv
// self-checking bench of the acquisition control block
`timescale 1ns/1ps
`include "aitc_cfg.svh"
module tb_aitc_ctrl
    import aitc_pkg::*;
;
    logic clk, nrst, start, stop, ext_sel, asel, fall, trg, atrg, we, smp_rdy, pen;
    logic adc_rdy, conv, acq, arm, done, ovr, err, sv, pclk, av;
    aitc_mode_e mode;
    logic [`AITC_DLY_W-1:0] dly;
    logic [`AITC_DIV_W-1:0] div;
    logic [`AITC_CODE_W-1:0] thr, dac, acode;
    logic [`AITC_CH_W-1:0] wch, ach;
    aitc_chcfg_s wcfg;
    aitc_sample_s smp;
    int n_fail = 0, checks = 0, n_conv = 0, n_pclk = 0, n_smp = 0, gap = 0, since = 0, m;
    aitc_ctrl u_aitc_ctrl (
        .sys_clk_in(clk), .nrst_in(nrst), .start_in(start), .stop_in(stop), .mode_in(mode),
        .delay_in(dly), .ext_clk_sel_in(ext_sel), .divisor_in(div), .trig_analog_sel_in(asel),
        .trig_fall_in(fall), .threshold_in(thr), .conversion_pacing_clock_in(pclk),
        .ext_trig_in(trg), .analog_trigger_inputs_in(atrg), .cfg_we_in(we), .cfg_chan_in(wch),
        .cfg_in(wcfg), .adc_valid_in(av), .adc_chan_in(ach), .adc_code_in(acode),
        .smp_ready_in(smp_rdy), .adc_ready_out(adc_rdy), .conv_start_out(conv),
        .threshold_dac_out(dac), .acquiring_out(acq), .armed_out(arm), .done_out(done),
        .overrun_out(ovr), .cfg_err_out(err), .smp_valid_out(sv), .smp_out(smp)
    );
    aitc_adc_model u_aitc_adc_model (.sys_clk_in(clk), .en_in(pen), .conv_start_in(conv),
        .pclk_out(pclk), .adc_valid_out(av), .adc_chan_out(ach), .adc_code_out(acode));
    always #2 clk = ~clk;
    // ******
    // tasks
    // ******
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // the trailing idle cycle keeps a strobe from being set twice in one time step
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
        cyc(1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // count conversions and taken words just after the stimulus edge, away from the clock edge
    always @(negedge clk) begin
        #1;
        if (conv) begin
            n_conv++;
            gap = since;
        end
        since = conv ? 1 : since + 1;
        if (sv && smp_rdy) begin
            n_smp++;
            chk(smp.value, smp.code ^ (smp.chan[0] ? 16'h8000 : 16'h0000));
            chk(smp.cfg, smp.chan[0] ? {AITC_GAIN_2, 1'b1} : {AITC_GAIN_1, 1'b0});
        end
    end
    always @(posedge pclk) n_pclk++;
    // ******
    // tests
    // ******
    initial begin
        {clk, nrst, start, stop, ext_sel, asel, fall, trg, atrg, we, pen} = '0;
        {dly, thr, wch, wcfg} = '0;
        mode = AITC_MODE_START;
        div = 32'h0000_01f4;
        smp_rdy = 1;
        cyc(5);
        nrst = 1;
        cyc(1);
        thr = 16'h7fff;
        cyc(1);
        chk(dac, 16'h7fff);
        // every gain code on both range kinds, written to a spare channel
        for (int g = 0; g < 8; g++) begin
            for (int b = 0; b < 2; b++) begin
                wch = 5'h02;
                wcfg = {g[2:0], b[0]};
                pulse(we);
                chk(err, (g > 4) || (g == 0 && b == 0));
            end
        end
        {wch, wcfg} = {5'h00, AITC_GAIN_1, 1'b0};
        pulse(we);
        {wch, wcfg} = {5'h01, AITC_GAIN_2, 1'b1};
        pulse(we);
        // start trigger on a rising TTL edge, divided internal pacing
        pulse(start);
        chk(arm, 1);
        m = n_conv;
        cyc(2600);
        chk(n_conv - m, 0);
        pulse(trg);
        cyc(3000);
        chk(acq, 1);
        chk(gap, 1250);
        pulse(stop);
        m = n_conv;
        cyc(1500);
        chk(acq, 0);
        chk(n_conv - m, 0);
        // stop trigger on a falling crossing; a rising one must be ignored
        {div, asel, fall, mode} = {32'h64, 1'b1, 1'b1, AITC_MODE_STOP};
        pulse(start);
        atrg = 1;
        cyc(2600);
        chk(acq, 1);
        chk(gap, 1000);
        atrg = 0;
        cyc(8);
        chk({acq, done}, 2'b01);
        // delay to start, falling TTL edge, external pacing; done needs a second start
        {asel, trg, ext_sel, pen, dly, mode} = {4'h7, 24'h2, AITC_MODE_DLY_START};
        pulse(start);
        pulse(start);
        @(posedge pclk);
        cyc(1);
        trg = 0;
        m = n_pclk;
        cyc(10);
        chk({arm, acq}, 2'b10);
        for (int i = m; i < 9000 && acq !== 1; i++) cyc(1);
        chk(n_pclk - m, 2);
        pulse(stop);
        // delay to stop, rising crossing, sample side stalled until after done
        {atrg, fall, smp_rdy, dly, mode} = {3'h0, 24'h3, AITC_MODE_DLY_STOP};
        asel = 1;
        pulse(start);
        cyc(2500);
        chk(acq, 1);
        @(posedge pclk);
        cyc(1);
        atrg = 1;
        m = n_conv;
        for (int i = 0; i < 6000 && done !== 1; i++) cyc(1);
        cyc(30);
        chk(n_conv - m, 4);
        chk({acq, done, adc_rdy, ovr, sv}, 5'h0b);
        smp_rdy = 1;
        m = n_smp;
        cyc(4);
        chk({n_smp - m, sv}, 2 << 1);
        tally_and_finish();
    end
    // cut a hang short well beyond the expected run length
    initial begin
        cyc(60000);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule
